// File: eba_pkg.sv
// Package with shared constants and types for external bus arbitration
package eba_pkg;
   localparam int ID_W     = 3;
   localparam int NUM_PEER = 6;
   localparam logic [2:0] ID_NONE  = 3'h0;
   localparam logic [2:0] ID_FIRST = 3'h1;
   localparam logic [2:0] ID_LAST  = 3'h6;
   // Clock cycles that the host grant floats before it is driven low
   localparam int GRANT_FLOAT_CYC = 1;
   typedef logic [ID_W-1:0]     eba_id_t;
   typedef logic [NUM_PEER-1:0] eba_req_t;
endpackage : eba_pkg

// File: eba_link_if.sv
// Interface joining the device arbiter and the host side
`timescale 1ns/10ps
interface eba_link_if;
   import eba_pkg::*;
   logic     host_request_n;
   logic     host_cs_n;
   logic     host_grant_n_o;
   logic     host_grant_n_oe;
   logic     host_grant_n_i;
   logic     host_ready_od_oe;
   logic     ext_dma_request_a_n;
   logic     ext_dma_request_b_n;
   logic     ext_dma_grant_a_n_o;
   logic     ext_dma_grant_b_n_o;
   logic     ext_dma_grant_oe;
   eba_req_t peer_bus_request_n;
   logic     own_request_n_o;
   logic     own_request_n_oe;
   logic     priority_access_n_o;
   logic     priority_access_n_oe;
   logic     priority_access_n_i;
   logic     arbitration_select;
   eba_id_t  processor_identity;

   modport device (
      input  host_request_n, host_cs_n, host_grant_n_i,
      input  ext_dma_request_a_n, ext_dma_request_b_n,
      input  peer_bus_request_n, priority_access_n_i,
      input  arbitration_select, processor_identity,
      output host_grant_n_o, host_grant_n_oe, host_ready_od_oe,
      output ext_dma_grant_a_n_o, ext_dma_grant_b_n_o, ext_dma_grant_oe,
      output own_request_n_o, own_request_n_oe,
      output priority_access_n_o, priority_access_n_oe
   );
   modport host (
      output host_request_n, host_cs_n,
      output ext_dma_request_a_n, ext_dma_request_b_n,
      output arbitration_select, processor_identity,
      input  host_grant_n_i, host_ready_od_oe,
      input  ext_dma_grant_a_n_o, ext_dma_grant_b_n_o, ext_dma_grant_oe
   );
endinterface : eba_link_if

// File: eba_device.sv
// Device end: host grant, wait states, DMA grants and peer arbitration
// Notes on behaviour
// - Grant host bus when host requests
// - Hold host grant low while request stays
// - Only bus master drives host grant (code: also while no master is valid)
// - Grant floats one cycle before going low
// - Host selects device with chip select
// - Pull ready low when select and request
// - Two DMA request inputs, channels 11, 12
// - DMA grant: transfer starts next cycle
// - Only master drives DMA grants
// - Identity picks own bus request line
// - Identity fixed, 000 or 001 single (code: with 000 the device never becomes master)
// - Drive own request, sample all others
// - Select high rotating, low fixed priority
// - Same select value on every processor
// - Non-master may assert priority access
// - Master releases bus, then grants host
// - Host request beats every peer request
`timescale 1ns/10ps
module eba_device
(
   input  wire logic            ref_clk,
   input  wire logic            srst,
   eba_link_if.device           link,
   input  wire logic            busWant,
   input  wire logic            priorityWant,
   input  wire logic            dmaBusyA,
   input  wire logic            dmaBusyB,
   output      logic            busMaster,
   output      logic            hostOwnsBus,
   output      logic            dmaStartA,
   output      logic            dmaStartB,
   output      eba_pkg::eba_id_t currentMaster
);
   import eba_pkg::*;

   typedef enum logic [1:0] {HG_IDLE, HG_FLOAT, HG_GRANT} eba_hg_t;

   eba_hg_t  hgState_r, hgState_nxt;
   eba_id_t  master_r, master_nxt;
   eba_id_t  lastMaster_r;
   logic     masterValid_r;
   logic     busMaster_r, hostOwns_r;
   logic     dmaStartA_r, dmaStartB_r, gntA_r, gntB_r;
   logic     ready_r, prio_r;
   eba_req_t reqVec;
   logic     hostReq, ownIdValid, anyPeer;
   logic     iAmMaster, winnerFound;
   eba_id_t  winnerId;

   // Own line driven from identity; others sampled
   assign ownIdValid = (link.processor_identity >= ID_FIRST) &&
                       (link.processor_identity <= ID_LAST);
   always_comb
   begin
      reqVec = ~link.peer_bus_request_n;
      if (ownIdValid)
         reqVec[link.processor_identity - ID_FIRST] = busWant;
   end
   assign hostReq   = ~link.host_request_n;
   assign anyPeer   = |reqVec;
   assign iAmMaster = masterValid_r &&
                      (master_r == link.processor_identity);

   // Pick next master: rotating after last one, or lowest identity
   always_comb
   begin
      eba_id_t cand;
      cand = ID_NONE;
      winnerFound = 1'b0;
      winnerId = ID_NONE;
      for (int k = 0; k < NUM_PEER; k++)
      begin
         if (link.arbitration_select)
            cand = eba_id_t'(((int'(lastMaster_r) + k) % NUM_PEER) + 1);
         else
            cand = eba_id_t'(k + 1);
         if (!winnerFound && reqVec[cand - ID_FIRST])
         begin
            winnerFound = 1'b1;
            winnerId = cand;
         end
      end
      master_nxt = master_r;
      // Current master keeps the bus while it still requests, unless priority access is low and this device is not master
      if (masterValid_r && reqVec[master_r - ID_FIRST] &&
          !(link.priority_access_n_i == 1'b0 && !iAmMaster))
         master_nxt = master_r;
      else if (winnerFound)
         master_nxt = winnerId;
   end

   // Host grant sequence: idle, float one cycle, then grant
   always_comb
   begin
      hgState_nxt = hgState_r;
      unique case (hgState_r)
         HG_IDLE:  if (hostReq) hgState_nxt = HG_FLOAT;
         HG_FLOAT: hgState_nxt = hostReq ? HG_GRANT : HG_IDLE;
         HG_GRANT: if (!hostReq) hgState_nxt = HG_IDLE;
      endcase
   end

   // Host grant state and bus ownership
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         hgState_r     <= HG_IDLE;
         master_r      <= ID_NONE;
         lastMaster_r  <= ID_LAST;
         masterValid_r <= 1'b0;
      end
      else
      begin
         hgState_r <= hgState_nxt;
         if (hostReq)
            masterValid_r <= masterValid_r;
         else if (anyPeer)
         begin
            masterValid_r <= 1'b1;
            master_r      <= master_nxt;
            if (master_nxt != master_r)
               lastMaster_r <= master_nxt;
         end
      end
   end

   // Registered outputs and pin drivers
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         busMaster_r <= 1'b0;
         hostOwns_r  <= 1'b0;
         gntA_r      <= 1'b0;
         gntB_r      <= 1'b0;
         dmaStartA_r <= 1'b0;
         dmaStartB_r <= 1'b0;
         ready_r     <= 1'b0;
         prio_r      <= 1'b0;
      end
      else
      begin
         // Bus released to host while host request stands
         busMaster_r <= iAmMaster && !hostReq;
         hostOwns_r  <= (hgState_nxt == HG_GRANT);
         gntA_r      <= iAmMaster && !hostReq && !dmaBusyA &&
                        !link.ext_dma_request_a_n && !gntA_r;
         gntB_r      <= iAmMaster && !hostReq && !dmaBusyB &&
                        !link.ext_dma_request_b_n && !gntB_r &&
                        link.ext_dma_request_a_n;
         dmaStartA_r <= gntA_r;
         dmaStartB_r <= gntB_r;
         ready_r     <= !link.host_cs_n && hostReq;
         prio_r      <= priorityWant && !iAmMaster;
      end
   end

   // Pin drivers: grant from master, or while no master is valid; float cycle has enable low
   assign link.host_grant_n_oe   = (iAmMaster || !masterValid_r) &&
                                   (hgState_r != HG_FLOAT);
   assign link.host_grant_n_o    = (hgState_r != HG_GRANT);
   assign link.host_ready_od_oe  = ready_r;
   assign link.ext_dma_grant_oe  = busMaster_r;
   assign link.ext_dma_grant_a_n_o = ~gntA_r;
   assign link.ext_dma_grant_b_n_o = ~gntB_r;
   assign link.own_request_n_o   = ~busWant;
   assign link.own_request_n_oe  = ownIdValid;
   assign link.priority_access_n_o  = 1'b0;
   assign link.priority_access_n_oe = prio_r;

   assign busMaster     = busMaster_r;
   assign hostOwnsBus   = hostOwns_r;
   assign dmaStartA     = dmaStartA_r;
   assign dmaStartB     = dmaStartB_r;
   assign currentMaster = master_r;
endmodule : eba_device

// File: eba_host.sv
// Host end: bus request, chip select, DMA requests and configuration
`timescale 1ns/10ps
module eba_host
(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   eba_link_if.host              link,
   input  wire logic             wantBus,
   input  wire logic             wantAccess,
   input  wire logic             dmaWantA,
   input  wire logic             dmaWantB,
   input  wire logic             rotateSel,
   input  wire eba_pkg::eba_id_t cfgIdentity,
   output      logic             granted,
   output      logic             waitState,
   output      logic             dmaGrantedA,
   output      logic             dmaGrantedB
);
   import eba_pkg::*;

   logic    req_r, cs_r, dmaA_r, dmaB_r, rot_r;
   logic    gnt_r, wait_r, gA_r, gB_r;
   eba_id_t id_r;

   // Request pins; identity captured only while reset is high
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         req_r  <= 1'b0;
         cs_r   <= 1'b0;
         dmaA_r <= 1'b0;
         dmaB_r <= 1'b0;
         rot_r  <= 1'b0;
         id_r   <= cfgIdentity;
      end
      else
      begin
         req_r  <= wantBus;
         cs_r   <= wantAccess && wantBus;
         dmaA_r <= dmaWantA;
         dmaB_r <= dmaWantB;
         rot_r  <= rotateSel;
      end
   end

   // Sample answers from the device
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         gnt_r  <= 1'b0;
         wait_r <= 1'b0;
         gA_r   <= 1'b0;
         gB_r   <= 1'b0;
      end
      else
      begin
         gnt_r  <= req_r && !link.host_grant_n_i;
         wait_r <= link.host_ready_od_oe;
         gA_r   <= link.ext_dma_grant_oe && !link.ext_dma_grant_a_n_o;
         gB_r   <= link.ext_dma_grant_oe && !link.ext_dma_grant_b_n_o;
      end
   end

   assign link.host_request_n      = ~req_r;
   assign link.host_cs_n           = ~cs_r;
   assign link.ext_dma_request_a_n = ~dmaA_r;
   assign link.ext_dma_request_b_n = ~dmaB_r;
   assign link.arbitration_select  = rot_r;
   assign link.processor_identity  = id_r;
   assign granted     = gnt_r;
   assign waitState   = wait_r;
   assign dmaGrantedA = gA_r;
   assign dmaGrantedB = gB_r;
endmodule : eba_host

// File: eba_assertions.sv
// Checker of the host grant, ready and DMA grant wires
`timescale 1ns/10ps
module eba_assertions
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic host_request_n,
   input wire logic host_cs_n,
   input wire logic host_grant_n_o,
   input wire logic host_grant_n_oe,
   input wire logic host_ready_od_oe,
   input wire logic ext_dma_grant_a_n_o,
   input wire logic ext_dma_grant_b_n_o,
   input wire logic ext_dma_grant_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Driven-low views of the grant pins
   wire logic hgLow = host_grant_n_oe && !host_grant_n_o;
   wire logic dmaA  = ext_dma_grant_oe && !ext_dma_grant_a_n_o;
   wire logic dmaB  = ext_dma_grant_oe && !ext_dma_grant_b_n_o;

   a_grant_float_once: assert property (
      $fell(host_request_n) && host_grant_n_oe
      |=> !host_grant_n_oe ##1 hgLow) else $error("grant float wrong");
   a_grant_hold: assert property (
      hgLow && !host_request_n |=> hgLow) else $error("grant dropped early");
   a_grant_release: assert property (
      hgLow && host_request_n |=> !hgLow) else $error("grant not released");
   a_grant_cause: assert property (
      hgLow |-> $past(host_request_n, 2) == 0)
      else $error("grant without request");
   a_ready_on_access: assert property (
      !host_cs_n && !host_request_n |=> host_ready_od_oe)
      else $error("ready not pulled");
   a_ready_cause: assert property (
      host_ready_od_oe |-> !$past(host_cs_n) && !$past(host_request_n))
      else $error("ready pulled alone");
   a_dma_pulse: assert property (
      dmaA || dmaB |=> !dmaA && !dmaB) else $error("dma grant too long");
   a_dma_pair: assert property (
      !(dmaA && dmaB)) else $error("two dma grants");
   a_host_blocks_dma: assert property (
      hgLow |-> !dmaA && !dmaB) else $error("dma grant under host");
endmodule : eba_assertions

// File: tb_external_bus_arbitration.sv
// Testbench joining the device end and the host end
`timescale 1ns/10ps
module tb_external_bus_arbitration;
   import eba_pkg::*;
   logic     ref_clk = 0, srst = 1, busWant = 0, prioWant = 0;
   logic     wantBus = 0, wantAccess = 0, dmaWantA = 0, dmaWantB = 0;
   logic     rotateSel = 0, busMaster, hostOwnsBus, dmaStartA;
   logic     granted, waitState, dmaStartB, dmaGrantedA, dmaGrantedB;
   eba_id_t  cfgId = ID_FIRST, currentMaster;
   eba_req_t peerReq = '1;
   int       n_errors = 0, comparisons = 0, cyc = 0, k;
   eba_id_t  rowId [4] = '{3'h1, 3'h3, 3'h4, 3'h6};
   eba_req_t rowLine [4] = '{6'h01, 6'h04, 6'h08, 6'h20};
   eba_link_if link ();

   // Pull-ups on grant and priority wires, own line merged into peers
   assign link.host_grant_n_i = link.host_grant_n_oe ?
      link.host_grant_n_o : 1'b1;
   assign link.priority_access_n_i = link.priority_access_n_oe ?
      link.priority_access_n_o : 1'b1;
   always_comb
   begin
      link.peer_bus_request_n = peerReq;
      if (link.own_request_n_oe && cfgId != ID_NONE)
         link.peer_bus_request_n[cfgId - 3'h1] = link.own_request_n_o;
   end

   eba_device u_eba_device (.ref_clk(ref_clk), .srst(srst), .link(link),
      .busWant(busWant), .priorityWant(prioWant), .dmaBusyA(1'b0),
      .dmaBusyB(1'b0), .busMaster(busMaster), .hostOwnsBus(hostOwnsBus),
      .dmaStartA(dmaStartA), .dmaStartB(dmaStartB),
      .currentMaster(currentMaster));
   eba_host u_eba_host (.ref_clk(ref_clk), .srst(srst), .link(link),
      .wantBus(wantBus), .wantAccess(wantAccess), .dmaWantA(dmaWantA),
      .dmaWantB(dmaWantB), .rotateSel(rotateSel), .cfgIdentity(cfgId),
      .granted(granted), .waitState(waitState),
      .dmaGrantedA(dmaGrantedA), .dmaGrantedB(dmaGrantedB));
   eba_assertions u_eba_assertions (.ref_clk(ref_clk), .srst(srst),
      .host_request_n(link.host_request_n), .host_cs_n(link.host_cs_n),
      .host_grant_n_o(link.host_grant_n_o),
      .host_grant_n_oe(link.host_grant_n_oe),
      .host_ready_od_oe(link.host_ready_od_oe),
      .ext_dma_grant_a_n_o(link.ext_dma_grant_a_n_o),
      .ext_dma_grant_b_n_o(link.ext_dma_grant_b_n_o),
      .ext_dma_grant_oe(link.ext_dma_grant_oe));

   // Clock and hang limit
   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic chk(input string nm, input logic [7:0] ex, got);
      comparisons++;
      if (got !== ex)
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      if (got !== ex)
         n_errors++;
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : step

   // Identity only changes while reset is held
   task automatic rst(input eba_id_t id);
      srst = 1;
      cfgId = id;
      step(6);
      srst = 0;
   endtask : rst

   task automatic end_of_test;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      busWant = 1;
      // Rows: identity beside the request line it must drive
      foreach (rowId[i])
      begin
         rst(rowId[i]);
         step(4);
         chk("ownLine", 8'(eba_req_t'(~rowLine[i])),
            8'(link.peer_bus_request_n));
         chk("master", 8'(rowId[i]), 8'(currentMaster));
      end
      // Host takes the bus from the master and holds it
      wantBus = 1;
      wantAccess = 1;
      for (k = 0; k < 20 && link.host_grant_n_i !== 1'b0; k++) step(1);
      step(5);
      chk("hostGrant", 8'h0, 8'(link.host_grant_n_i));
      chk("granted", 8'h1, 8'(granted));
      chk("wait", 8'h1, 8'(waitState));
      chk("owns", 8'h1, 8'(hostOwnsBus));
      chk("yield", 8'h0, 8'(busMaster));
      wantBus = 0;
      wantAccess = 0;
      step(6);
      chk("hostFree", 8'h1, 8'(link.host_grant_n_i));
      chk("reclaim", 8'h1, 8'(busMaster));
      chk("waitOff", 8'h0, 8'(waitState));
      // DMA channel A, channel B, then both at once
      for (int c = 0; c < 3; c++)
      begin
         dmaWantA = c != 1;
         dmaWantB = c != 0;
         for (k = 0; k < 20 && (link.ext_dma_grant_a_n_o &
            link.ext_dma_grant_b_n_o) !== 1'b0; k++) step(1);
         chk("dmaGrantA", 8'(c == 1), 8'(link.ext_dma_grant_a_n_o));
         step(1);
         chk("dmaStartA", 8'(c != 1), 8'(dmaStartA));
         chk("dmaStartB", 8'(c == 1), 8'(dmaStartB));
         chk("hostDmaA", 8'(c != 1), 8'(dmaGrantedA));
         chk("hostDmaB", 8'(c == 1), 8'(dmaGrantedB));
         dmaWantA = 0;
         dmaWantB = 0;
         step(8);
      end
      // Fixed order: peer 1 beats identity 2; a slave drives no grants
      peerReq = 6'h3e;
      rst(3'h2);
      step(4);
      chk("fixedWin", 8'h1, 8'(currentMaster));
      wantBus = 1;
      prioWant = 1;
      step(6);
      chk("grantOe", 8'h0, 8'(link.host_grant_n_oe));
      chk("dmaOe", 8'h0, 8'(link.ext_dma_grant_oe));
      chk("prio", 8'h0, 8'(link.priority_access_n_i));
      wantBus = 0;
      prioWant = 0;
      // Rotating order: after identity 2, peer 3 beats peer 1
      rotateSel = 1;
      peerReq = '1;
      rst(3'h2);
      step(4);
      peerReq = 6'h3a;
      busWant = 0;
      step(6);
      chk("rotWin", 8'h3, 8'(currentMaster));
      end_of_test();
   end
endmodule : tb_external_bus_arbitration
